// [puc_pkg.sv]
// Shared constants for the presettable up/down counter and its controller.
// Summary of operation
// - Count only on rising edge of count input.
// - Four-bit state, binary or 8-4-2-1 decade.
// - Wrap fifteen/nine to zero and back.
// - Direction low counts up, high counts down.
// - Count only while active-low enable is low.
// - Load low copies data inputs into state.
// - Max/min high at top going up, zero going down.
// - Ripple output low: enabled, max/min, count low.
// - Change direction only while count input high, settled.
// - Keep count pulses wide against ripple glitches.
// - Divider: ripple output reloads data at terminal count.
// - Dual variant: up input increments, down decrements.
// - Hold the unused dual count input high.
// - Clear high forces state to zero.
// - Clear overrides load, data and counts.
// - Carry high at maximum while up input low.
// - Borrow high at zero while down input low.
package puc_pkg;

    // ************************************************************
    // Counter geometry and reset values.
    // ************************************************************
    localparam int         PUC_W       = 4;
    localparam logic [3:0] PUC_BIN_MAX = 4'hF;
    localparam logic [3:0] PUC_DEC_MAX = 4'h9;
    localparam logic [3:0] PUC_CNT_RST = 4'h0;

    // ************************************************************
    // Controller register map (address 4 bits, data 8 bits).
    // ************************************************************
    localparam logic [3:0] PUC_REG_CTRL     = 4'h0;
    localparam logic [3:0] PUC_REG_DATA     = 4'h1;
    localparam logic [3:0] PUC_REG_CMD      = 4'h2;
    localparam logic [3:0] PUC_REG_STATUS   = 4'h3;
    localparam logic [3:0] PUC_REG_IRQ_STAT = 4'h4;
    localparam logic [3:0] PUC_REG_IRQ_CLR  = 4'h5;
    localparam logic [3:0] PUC_REG_IRQ_EN   = 4'h6;

    // Control register fields and reset value.
    localparam int         PUC_CTRL_DIR    = 0;
    localparam int         PUC_CTRL_ENA_N  = 1;
    localparam int         PUC_CTRL_RELOAD = 2;
    localparam int         PUC_CTRL_RUN    = 3;
    localparam logic [7:0] PUC_CTRL_RST    = 8'h00;
    localparam logic [3:0] PUC_DATA_RST    = 4'h0;

    // Command register fields (write-only, self-clearing).
    localparam int PUC_CMD_LOAD  = 0;
    localparam int PUC_CMD_CLEAR = 1;
    localparam int PUC_CMD_UP    = 2;
    localparam int PUC_CMD_DOWN  = 3;

    // Status register fields; bits 3:0 hold the count.
    localparam int PUC_ST_MAXMIN = 4;
    localparam int PUC_ST_RCO_N  = 5;
    localparam int PUC_ST_CARRY  = 6;
    localparam int PUC_ST_BORROW = 7;

    // Interrupt bits, same layout in status, clear and enable.
    localparam int         PUC_IRQ_MAXMIN = 0;
    localparam int         PUC_IRQ_RIPPLE = 1;
    localparam int         PUC_IRQ_CARRY  = 2;
    localparam int         PUC_IRQ_BORROW = 3;
    localparam int         PUC_IRQ_DONE   = 4;
    localparam int         PUC_IRQ_N      = 5;
    localparam logic [4:0] PUC_IRQ_RST    = 5'h00;

    // ************************************************************
    // Count pulse timing at 50 MHz.
    // ************************************************************
    localparam int         PUC_CLK_NS     = 20;
    localparam int         PUC_LOW_NS     = 100;
    localparam int         PUC_SETTLE_NS  = 100;
    localparam logic [7:0] PUC_LOW_CYC    =
        8'((PUC_LOW_NS + PUC_CLK_NS - 1) / PUC_CLK_NS);
    localparam logic [7:0] PUC_SETTLE_CYC =
        8'((PUC_SETTLE_NS + PUC_CLK_NS - 1) / PUC_CLK_NS);

endpackage

// [puc_if.sv]
// Pin-level interface between the counter and its controlling logic.
`timescale 1ns/1ps
interface puc_if;

    // Count inputs, idle high; single-clock variant uses cnt_up only.
    logic       cnt_up;
    logic       cnt_dn;
    // Single-clock controls.
    logic       dir_down;
    logic       enable_n;
    // Shared preset and dual-clock clear.
    logic       load_n;
    logic       clear;
    logic [3:0] data;
    // Counter state bits.
    logic       count_bit0;
    logic       count_bit1;
    logic       count_bit2;
    logic       count_bit3;
    // Cascade outputs.
    logic       max_min;
    logic       ripple_count_out_n;
    logic       carry;
    logic       borrow;

    modport dev (
        input  cnt_up, cnt_dn, dir_down, enable_n, load_n, clear, data,
        output count_bit0, count_bit1, count_bit2, count_bit3,
        output max_min, ripple_count_out_n, carry, borrow
    );

    modport ctl (
        output cnt_up, cnt_dn, dir_down, enable_n, load_n, clear, data,
        input  count_bit0, count_bit1, count_bit2, count_bit3,
        input  max_min, ripple_count_out_n, carry, borrow
    );

endinterface

// [puc_dev.sv]
// Presettable four-bit up/down counter, single- or dual-clock variant.
`timescale 1ns/1ps
module puc_dev #(
    parameter bit DECADE     = 1'b0,
    parameter bit DUAL_CLOCK = 1'b0
) (
    // Clock and reset.
    input  wire logic   sys_clk,
    input  wire logic   sys_rst,
    // Pin side towards the controlling logic.
    puc_if.dev          link,
    // User side.
    output logic [3:0]  count_value,
    output logic        wrap_pulse,
    output logic        load_active
);
    import puc_pkg::*;

    // ************************************************************
    // State record and derived constants.
    // ************************************************************

    // All state of the counter lives in one record.
    typedef struct packed {
        logic [3:0] count;

        logic       up_prev;
        logic       dn_prev;

        logic       max_min;
        logic       rco_n;

        logic       carry;
        logic       borrow;

        logic       wrap;
        logic       loading;
    } puc_dev_st_t;

    // Count inputs idle high, so the edge memories start high to
    // avoid a phantom rising edge right after reset.
    localparam puc_dev_st_t DEV_RST = '{
        count:   PUC_CNT_RST,
        up_prev: 1'b1,
        dn_prev: 1'b1,

        max_min: 1'b0,
        rco_n:   1'b1,

        carry:   1'b0,
        borrow:  1'b0,

        wrap:    1'b0,
        loading: 1'b0
    };

    // Top of the sequence depends on the counting code.
    localparam logic [3:0] CNT_MAX = DECADE ? PUC_DEC_MAX : PUC_BIN_MAX;

    puc_dev_st_t s_q;
    puc_dev_st_t s_d;

    logic        up_rise;
    logic        dn_rise;

    logic        step_up;
    logic        step_dn;

    logic [3:0]  inc_val;
    logic [3:0]  dec_val;

    logic        ena_single;

    // ************************************************************
    // Edge detection and step decode.
    // ************************************************************

    // Pins are synchronous to sys_clk, so a registered copy is enough
    // to find the low-to-high transition of each count input.
    always_comb begin
        up_rise    = link.cnt_up & ~s_q.up_prev;
        dn_rise    = link.cnt_dn & ~s_q.dn_prev;

        ena_single = ~link.enable_n;

        // No step unless a count edge is decoded below.
        step_up    = 1'b0;
        step_dn    = 1'b0;

        if (DUAL_CLOCK) begin
            // Both inputs rising together cancel; the controller keeps
            // the idle input high so this should never happen.
            step_up = up_rise & ~dn_rise;
            step_dn = dn_rise & ~up_rise;
        end else if (ena_single && up_rise) begin
            step_up = ~link.dir_down;
            step_dn = link.dir_down;
        end
    end

    // ************************************************************
    // Sequence arithmetic.
    // ************************************************************

    // Decade mode also leaves any preset above nine towards zero on
    // the next up count, so illegal codes never trap the counter.
    always_comb begin
        if (s_q.count >= CNT_MAX) begin
            inc_val = 4'h0;
        end else begin
            inc_val = 4'(s_q.count + 4'h1);
        end

        // Down from zero lands on the top code.
        if (s_q.count == 4'h0) begin
            dec_val = CNT_MAX;
        end else begin
            dec_val = 4'(s_q.count - 4'h1);
        end
    end

    // ************************************************************
    // Next-state logic.
    // ************************************************************

    // Priority: clear, then load, then counting. Load and clear are
    // levels and win at every edge while they are held, which stands
    // in for the asynchronous overrides of the original part.
    always_comb begin
        s_d         = s_q;
        s_d.up_prev = link.cnt_up;
        s_d.dn_prev = link.cnt_dn;

        s_d.wrap    = 1'b0;
        s_d.loading = 1'b0;

        if (DUAL_CLOCK && link.clear) begin
            s_d.count = PUC_CNT_RST;
        end else if (!link.load_n) begin
            s_d.count   = link.data;
            s_d.loading = 1'b1;
        end else if (step_up) begin
            s_d.count = inc_val;
            s_d.wrap  = (s_q.count == CNT_MAX);
        end else if (step_dn) begin
            s_d.count = dec_val;
            s_d.wrap  = (s_q.count == 4'h0);
        end

        // Cascade flags follow the new state and the present pins.
        // Being registered, the flags lag the pins by one edge.
        if (DUAL_CLOCK) begin
            s_d.max_min = 1'b0;
            s_d.rco_n   = 1'b1;

            s_d.carry   = (s_d.count == CNT_MAX) & ~link.cnt_up;
            s_d.borrow  = (s_d.count == 4'h0) & ~link.cnt_dn;
        end else begin
            s_d.max_min = ((s_d.count == CNT_MAX) & ~link.dir_down) |
                          ((s_d.count == 4'h0) & link.dir_down);

            // The ripple output follows the low half of the count
            // pulse; it is the divider's reload strobe as well.
            s_d.rco_n   = ~(ena_single & s_d.max_min &
                            ~link.cnt_up);

            s_d.carry   = 1'b0;
            s_d.borrow  = 1'b0;
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************

    // Synchronous reset returns the counter to zero with flags idle.
    // The whole record moves on every edge; there is no enable.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_q <= DEV_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs, each straight from the state register.
    // ************************************************************

    // Pin side.
    assign link.count_bit0         = s_q.count[0];
    assign link.count_bit1         = s_q.count[1];
    assign link.count_bit2         = s_q.count[2];
    assign link.count_bit3         = s_q.count[3];

    assign link.max_min            = s_q.max_min;
    assign link.ripple_count_out_n = s_q.rco_n;

    assign link.carry              = s_q.carry;
    assign link.borrow             = s_q.borrow;

    // User side: value mirror, wrap strobe and load indication.
    assign count_value = s_q.count;
    assign wrap_pulse  = s_q.wrap;
    assign load_active = s_q.loading;

endmodule // puc_dev

// [puc_ctl.sv]
// Controlling logic that drives the counter pins from software registers.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module puc_ctl #(
    parameter bit DUAL_CLOCK = 1'b0
) (
    // Clock and reset.
    input  wire logic   sys_clk,
    input  wire logic   sys_rst,
    // Pin side towards the counter.
    puc_if.ctl          link,
    // Software register port.
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic [7:0]      rd_data,
    // Interrupt.
    output logic            irq
);
    import puc_pkg::*;

    // ************************************************************
    // State record.
    // ************************************************************
    typedef enum logic [1:0] {IDLE, SETUP, LOW, SETTLE} puc_ph_t;

    typedef struct packed {
        puc_ph_t    ph;
        logic [7:0] tmr;
        logic       sel_dn;
        logic [7:0] ctrl;
        logic [3:0] data;
        logic [4:0] ist;
        logic [4:0] ien;
        logic [7:0] rdat;
        logic       irq;
        logic       cnt_up;
        logic       cnt_dn;
        logic       dir;
        logic       load_n;
        logic       clear;
        logic [7:0] pins_prev;
    } puc_ctl_st_t;

    puc_ctl_st_t s_q;
    puc_ctl_st_t s_d;
    logic [7:0]  pins;
    logic [4:0]  ev;
    logic        wr_cmd;
    logic        go_up;
    logic        go_dn;

    // Sampled counter outputs in status-register layout.
    assign pins = {link.borrow, link.carry, link.ripple_count_out_n,
                   link.max_min, link.count_bit3, link.count_bit2,
                   link.count_bit1, link.count_bit0};

    // ************************************************************
    // Next-state logic.
    // ************************************************************
    always_comb begin
        s_d           = s_q;
        s_d.pins_prev = pins;
        s_d.clear     = 1'b0;
        s_d.rdat      = 8'h00;
        wr_cmd        = wr_en && (addr == PUC_REG_CMD);
        go_up = (wr_cmd && wr_data[PUC_CMD_UP]) ||
                (s_q.ctrl[PUC_CTRL_RUN] && !s_q.ctrl[PUC_CTRL_DIR]);
        go_dn = (wr_cmd && wr_data[PUC_CMD_DOWN] && !go_up) ||
                (s_q.ctrl[PUC_CTRL_RUN] && s_q.ctrl[PUC_CTRL_DIR]);

        // Edge events from the counter outputs.
        ev = '0;
        ev[PUC_IRQ_MAXMIN] = pins[PUC_ST_MAXMIN] &
            ~s_q.pins_prev[PUC_ST_MAXMIN];
        ev[PUC_IRQ_RIPPLE] = ~pins[PUC_ST_RCO_N] & s_q.pins_prev[PUC_ST_RCO_N];
        ev[PUC_IRQ_CARRY]  = pins[PUC_ST_CARRY] & ~s_q.pins_prev[PUC_ST_CARRY];
        ev[PUC_IRQ_BORROW] = pins[PUC_ST_BORROW] &
            ~s_q.pins_prev[PUC_ST_BORROW];

        // Pulse engine; commands arriving while busy are dropped.
        case (s_q.ph)
            IDLE: begin
                if (go_up || go_dn) begin
                    // Direction moves only here, with both pins high.
                    s_d.dir    = go_dn;
                    s_d.sel_dn = DUAL_CLOCK && go_dn;
                    s_d.ph     = SETUP;
                end
            end
            SETUP: begin
                s_d.ph  = LOW;
                s_d.tmr = PUC_LOW_CYC;
                if (s_q.sel_dn) begin
                    s_d.cnt_dn = 1'b0;
                end else begin
                    s_d.cnt_up = 1'b0;
                end
            end
            LOW: begin
                // A wide low half masks ripple output glitches.
                if (s_q.tmr <= 8'h01) begin
                    s_d.cnt_up = 1'b1;
                    s_d.cnt_dn = 1'b1;
                    s_d.tmr    = PUC_SETTLE_CYC;
                    s_d.ph     = SETTLE;
                end else begin
                    s_d.tmr = 8'(s_q.tmr - 8'h01);
                end
            end
            SETTLE: begin
                // Hold off the next direction change until settled.
                if (s_q.tmr <= 8'h01) begin
                    s_d.ph           = IDLE;
                    ev[PUC_IRQ_DONE] = 1'b1;
                end else begin
                    s_d.tmr = 8'(s_q.tmr - 8'h01);
                end
            end
            default: begin
                s_d.ph = IDLE;
            end
        endcase

        // Load pin: divider reload from the ripple output, else command.
        if (s_q.ctrl[PUC_CTRL_RELOAD]) begin
            s_d.load_n = link.ripple_count_out_n;
        end else begin
            s_d.load_n = ~(wr_cmd && wr_data[PUC_CMD_LOAD]);
        end
        s_d.clear = wr_cmd && wr_data[PUC_CMD_CLEAR];

        // Register writes; interrupt set wins over clear.
        if (wr_en && addr == PUC_REG_CTRL) begin
            s_d.ctrl = wr_data;
        end
        if (wr_en && addr == PUC_REG_DATA) begin
            s_d.data = wr_data[3:0];
        end
        if (wr_en && addr == PUC_REG_IRQ_EN) begin
            s_d.ien = wr_data[4:0];
        end
        if (wr_en && addr == PUC_REG_IRQ_CLR) begin
            s_d.ist = s_q.ist & ~wr_data[4:0];
        end
        s_d.ist = s_d.ist | ev;
        s_d.irq = |(s_d.ist & s_d.ien);

        // Reads answer in the next cycle only; unmapped reads give zero.
        if (rd_en) begin
            case (addr)
                PUC_REG_CTRL:     s_d.rdat = s_q.ctrl;
                PUC_REG_DATA:     s_d.rdat = {4'h0, s_q.data};
                PUC_REG_STATUS:   s_d.rdat = pins;
                PUC_REG_IRQ_STAT: s_d.rdat = {3'h0, s_q.ist};
                PUC_REG_IRQ_EN:   s_d.rdat = {3'h0, s_q.ien};
                default:          s_d.rdat = 8'h00;
            endcase
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_q           <= '0;
            s_q.ph        <= IDLE;
            s_q.ctrl      <= PUC_CTRL_RST;
            s_q.data      <= PUC_DATA_RST;
            s_q.ist       <= PUC_IRQ_RST;
            s_q.ien       <= PUC_IRQ_RST;
            s_q.cnt_up    <= 1'b1;
            s_q.cnt_dn    <= 1'b1;
            s_q.load_n    <= 1'b1;
            s_q.pins_prev <= 8'h20;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign link.cnt_up   = s_q.cnt_up;
    assign link.cnt_dn   = s_q.cnt_dn;
    assign link.dir_down = s_q.dir;
    assign link.enable_n = s_q.ctrl[PUC_CTRL_ENA_N];
    assign link.load_n   = s_q.load_n;
    assign link.clear    = s_q.clear;
    assign link.data     = s_q.data;
    assign rd_data       = s_q.rdat;
    assign irq           = s_q.irq;

endmodule // puc_ctl

// [puc_monitor.sv]
// Pin-level assertions between the counter and its controlling logic.
`timescale 1ns/1ps
module puc_monitor #(
    parameter logic [3:0] TOP = puc_pkg::PUC_BIN_MAX
) (
    // Clock and reset.
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // Pins driven by the controller.
    input wire logic       cnt_up,
    input wire logic       dir_down,
    input wire logic       enable_n,
    input wire logic       load_n,
    input wire logic [3:0] data,
    // Pins driven by the counter.
    input wire logic       count_bit0,
    input wire logic       count_bit1,
    input wire logic       count_bit2,
    input wire logic       count_bit3,
    input wire logic       max_min,
    input wire logic       ripple_count_out_n
);
    import puc_pkg::*;

    // ************************************************************
    // Helper logic and step sequences.
    // ************************************************************
    logic [3:0] cnt;
    logic       up_q;
    logic       rise;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // Count state gathered from the loose bits.
    assign cnt  = {count_bit3, count_bit2, count_bit1, count_bit0};
    assign rise = cnt_up && !up_q;

    // Last level of the count input; idle high so reset shows no edge.
    always_ff @(posedge sys_clk) begin
        up_q <= sys_rst ? 1'b1 : cnt_up;
    end

    sequence s_armed;
        load_n && !enable_n && rise;
    endsequence
    sequence s_step_up;
        s_armed ##0 !dir_down;
    endsequence
    sequence s_step_dn;
        s_armed ##0 dir_down;
    endsequence

    // ************************************************************
    // Assertions.
    // ************************************************************
    chk_step_up: assert property (
        s_step_up |=> cnt == $past(cnt) + 4'h1)
        else $error("count did not advance by one");
    chk_step_down: assert property (
        s_step_dn |=> cnt == $past(cnt) - 4'h1)
        else $error("count did not go back by one");
    chk_load_copy: assert property (
        !load_n |=> cnt == $past(data))
        else $error("preset data not copied");
    chk_enable_hold: assert property (
        load_n && enable_n |=> $stable(cnt))
        else $error("count moved while disabled");
    chk_rise_only: assert property (
        load_n && !rise |=> $stable(cnt))
        else $error("count moved without a rising edge");
    // Only judged on a settled state, so either flag timing is accepted.
    chk_maxmin_flag: assert property (
        $stable(cnt) && $stable(dir_down) ##1 $stable(cnt) |->
        max_min == ((cnt == TOP && !$past(dir_down)) ||
                    (cnt == 4'h0 && $past(dir_down))))
        else $error("max/min flag wrong");
    chk_ripple_cause: assert property (
        !ripple_count_out_n |-> !$past(enable_n) && !$past(cnt_up))
        else $error("ripple output low without its cause");
    chk_ripple_low: assert property (
        !$past(enable_n) && !$past(cnt_up) && max_min && $past(max_min)
        |-> !ripple_count_out_n)
        else $error("ripple output missed terminal count");
    chk_dir_quiet: assert property (
        $changed(dir_down) |-> cnt_up && $past(cnt_up))
        else $error("direction changed during a count pulse");

endmodule // puc_monitor

// [presettable_updown_counter_bench.sv]
// Testbench joining the counter and its controller across the pin bundle.
`timescale 1ns/1ps
module presettable_updown_counter_bench;
    import puc_pkg::*;
    typedef struct {
        string      what;
        logic [7:0] exp;
        logic [7:0] mask;
    } puc_note_t;

    logic       sys_clk;
    logic       sys_rst;
    logic [3:0] addr;
    logic [7:0] wr_data;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rd_data;
    logic       irq;
    logic [3:0] count_value;
    logic       wrap_pulse;
    logic       load_active;
    logic       rd_q;
    logic [3:0] base;
    int         num_errors;
    int         checks;
    int         wraps;
    int         seed;
    int         low_cnt;
    puc_note_t  note;
    puc_note_t  notes[$];

    puc_if link_if();
    puc_dev #(.DECADE(1'b0), .DUAL_CLOCK(1'b0)) i_puc_dev (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_if.dev),
        .count_value(count_value), .wrap_pulse(wrap_pulse),
        .load_active(load_active));
    puc_ctl #(.DUAL_CLOCK(1'b0)) i_puc_ctl (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_if.ctl),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .irq(irq));
    puc_monitor #(.TOP(PUC_BIN_MAX)) i_puc_monitor (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .cnt_up(link_if.cnt_up),
        .dir_down(link_if.dir_down), .enable_n(link_if.enable_n),
        .load_n(link_if.load_n), .data(link_if.data),
        .count_bit0(link_if.count_bit0), .count_bit1(link_if.count_bit1),
        .count_bit2(link_if.count_bit2), .count_bit3(link_if.count_bit3),
        .max_min(link_if.max_min),
        .ripple_count_out_n(link_if.ripple_count_out_n));

    // ************************************************************
    // Clock, watchdog, checking and bus tasks.
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // About ten thousand cycles; the tests need well under half of that.
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check_val(input string w, input logic [7:0] e,
                             input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask

    // Read answers retire the oldest note; values are taken before the edge.
    always @(posedge sys_clk) begin
        if (rd_q === 1'b1) begin
            note = notes.pop_front();
            check_val(note.what, note.exp & note.mask, rd_data & note.mask);
        end
        if (wrap_pulse === 1'b1) begin
            wraps++;
        end
        rd_q <= rd_en;
    end

    // Strobe tasks set both strobes once, so back-to-back calls never
    // assign a signal twice in one time step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        rd_en   <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e,
                      input logic [7:0] m, input string w);
        addr  <= a;
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        notes.push_back('{w, e, m});
        @(posedge sys_clk);
    endtask

    task automatic idle();
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge sys_clk);
    endtask

    function automatic logic [7:0] st(input logic [3:0] c, input logic dn);
        logic mm;
        mm = (c == PUC_BIN_MAX && !dn) || (c == 4'h0 && dn);
        return {3'b001, mm, c};
    endfunction

    task automatic ld(input logic [3:0] d);
        wr(PUC_REG_DATA, {4'h0, d});
        wr(PUC_REG_CMD, 8'h01);
        idle();
        @(posedge sys_clk);
        check_val("load", 8'h01, {7'h0, load_active});
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic step(input logic dn, input logic [3:0] c);
        wr(PUC_REG_CMD, dn ? 8'h08 : 8'h04);
        idle();
        repeat (PUC_LOW_CYC + PUC_SETTLE_CYC + 8) @(posedge sys_clk);
        rd(PUC_REG_STATUS, st(c, dn), 8'hFF, "status");
        idle();
        check_val("count", {4'h0, c}, {4'h0, count_value});
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        seed = 32'h7129c171;
        sys_rst = 1'b1;
        addr = 4'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // Reset values, a write-only place and an unmapped address.
        rd(PUC_REG_CTRL, 8'h00, 8'hFF, "ctrl");
        rd(PUC_REG_DATA, 8'h00, 8'hFF, "data");
        rd(PUC_REG_STATUS, st(4'h0, 1'b0), 8'hFF, "status");
        rd(PUC_REG_IRQ_STAT, 8'h00, 8'hFF, "irq status");
        rd(PUC_REG_CMD, 8'h00, 8'hFF, "cmd");
        rd(4'hF, 8'h00, 8'hFF, "unmapped");
        wr(PUC_REG_IRQ_EN, 8'h10);
        idle();
        repeat (4) begin
            base = 4'($random(seed));
            ld(base);
            rd(PUC_REG_STATUS, st(base, 1'b0), 8'hFF, "status");
            idle();
        end
        // Wrap both ways around the top and bottom codes.
        ld(4'hE);
        step(1'b0, 4'hF);
        step(1'b0, 4'h0);
        step(1'b0, 4'h1);
        step(1'b1, 4'h0);
        step(1'b1, 4'hF);
        step(1'b1, 4'hE);
        check_val("wraps", 8'h02, 8'(wraps));
        wr(PUC_REG_CTRL, 8'h02);
        step(1'b0, 4'hE);
        wr(PUC_REG_CTRL, 8'h00);
        idle();
        // Interrupt: pending done event raised, masked, unmasked, cleared.
        check_val("irq", 8'h01, {7'h0, irq});
        wr(PUC_REG_IRQ_EN, 8'h00);
        idle();
        repeat (2) @(posedge sys_clk);
        check_val("irq masked", 8'h00, {7'h0, irq});
        wr(PUC_REG_IRQ_EN, 8'h10);
        idle();
        repeat (2) @(posedge sys_clk);
        check_val("irq", 8'h01, {7'h0, irq});
        wr(PUC_REG_IRQ_CLR, 8'h1F);
        idle();
        repeat (2) @(posedge sys_clk);
        check_val("irq cleared", 8'h00, {7'h0, irq});
        // Divider: the ripple output reloads the preset at the top code.
        base = {2'b10, 2'($random(seed))};
        ld(base);
        wr(PUC_REG_CTRL, 8'h0C);
        idle();
        low_cnt = 0;
        repeat (400) begin
            @(posedge sys_clk);
            if (count_value < base) begin
                low_cnt++;
            end
        end
        check_val("divider floor", 8'h00, 8'(low_cnt));
        rd(PUC_REG_IRQ_STAT, 8'h02, 8'h02, "ripple event");
        wr(PUC_REG_CTRL, 8'h00);
        idle();
        stop_test();
    end

endmodule // presettable_updown_counter_bench
